//--- sami_pkg.sv
package sami_pkg;
  // =====================================================================
  // sizes and counts
  localparam int unsigned RESULT_W   = 8;
  localparam int unsigned CONV_BITS  = 8;     // decisions after the address
  localparam int unsigned CH_W       = 8;     // analog channel selects
  localparam int unsigned COM_BIT    = 8;     // common return input select
  // =====================================================================
  // host clock limits, kept for checks on the far side
  localparam int unsigned CLK_NS        = 25;
  localparam int unsigned MIN_PHASE_NS  = 1000;
  localparam int unsigned MAX_HIGH_NS   = 60000;
  localparam int unsigned MIN_PHASE_CYC = (MIN_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MAX_HIGH_CYC  = MAX_HIGH_NS / CLK_NS;
  // =====================================================================
  // values and forced address bits
  localparam logic [2:0] BIT_TOP    = 3'h7;
  localparam logic [2:0] BIT_ONE    = 3'h1;
  localparam logic [7:0] TRIAL_INIT = 8'h80;
  localparam logic [7:0] ZERO8      = 8'h00;
  localparam logic [8:0] ONE9       = 9'h001;
  localparam logic       SEL0_CH4   = 1'h1;
  localparam logic       SEL0_CH2   = 1'h0;
  localparam logic       SEL1_CH2   = 1'h1;
  // =====================================================================
  // sequence states, gray along the path through ST_LSB
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_SETTLE = 3'h3,
    ST_CONV   = 3'h2,
    ST_LSB    = 3'h6,
    ST_DONE   = 3'h7
  } sami_state_type;
endpackage : sami_pkg

//--- sami_core.sv
`timescale 1ns/10ps
// Notes on behaviour
// - after the address, the approximation takes exactly eight serial clocks
// - serial input is sampled on rising serial clock edges
// - serial output changes only after falling edges or chip select high, held until next fall
// - chip select high releases serial output and busy line at once
// - four-channel: input loads pair-select-high, pair-select-low forced to 1
// - two-channel: input loads polarity, select low 0, select high 1
// - converts positive input minus negative input
// - positive below negative gives all-zero code, no sign
// - configuration latched from each address before its conversion
// - address picks enabled inputs and single-ended or differential
// - differential address sets which pair member is positive
// - differential pairs only from adjacent channels within one pair
// - address arrives serially; single-input variant takes none
// - eight-channel single-ended uses common return as negative
// - sequence runs while chip select low, waiting start and address
// - leading zeros skipped, first one is start, then 2-4 address bits
// - half-clock settle, then busy high, input off, leading zero out
// - each decision shown at a falling edge, most significant first
module sami_core #(
  parameter int unsigned CHANNELS = 8
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cs_n,
  input  wire logic       i_sclk,
  input  wire logic       i_serial_in,
  input  wire logic       i_shift_order_enable_n,
  input  wire logic       i_comp_high,
  input  wire logic       i_pos_below_neg,
  output logic            o_serial_out,
  output logic            o_serial_out_oe_n,
  output logic            o_conversion_active,
  output logic            o_conversion_active_oe_n,
  output logic            o_single_ended_select,
  output logic [7:0]      o_pos_sel,
  output logic [8:0]      o_neg_sel,
  output logic [7:0]      o_ladder_code,
  output logic [7:0]      o_result
);
  // =====================================================================
  // address length per variant
  localparam logic [2:0] ADDR_N = (CHANNELS == 8) ? 3'h4 :
                                  (CHANNELS == 4) ? 3'h3 :
                                  (CHANNELS == 2) ? 3'h2 : 3'h0;

  // channel selects from the latched address fields
  function automatic logic [16:0] mux_decode(input logic sgl, input logic odd,
                                             input logic s1, input logic s0);
    logic [2:0] idx;
    logic [7:0] pos;
    logic [8:0] neg;
    idx = 3'h0;
    pos = 8'h00;
    neg = 9'h000;
    if (CHANNELS == 8) idx = {s1, s0, odd};
    else if (CHANNELS == 4) idx = {1'b0, s1, odd};
    else if (CHANNELS == 2) idx = {2'b00, odd};
    if (CHANNELS == 1) begin
      pos = 8'h01;                                 // fixed polarity
      neg = 9'h002;
    end else if (sgl) begin
      pos = 8'(sami_pkg::ONE9 << idx);
      neg = sami_pkg::ONE9 << sami_pkg::COM_BIT;
    end else begin
      pos = 8'(sami_pkg::ONE9 << idx);
      neg = sami_pkg::ONE9 << {idx[2:1], ~idx[0]};
    end
    mux_decode = {pos, neg};
  endfunction : mux_decode

  // =====================================================================
  // state
  sami_pkg::sami_state_type state, next_state;
  logic       sclk_q;
  logic [3:0] addr_sr, next_addr_sr;
  logic [2:0] cnt, next_cnt;
  logic [7:0] trial, next_trial;
  logic [7:0] result, next_result;
  logic       dout, next_dout;
  logic       drive, next_drive;
  logic       busy, next_busy;
  logic       sgl, next_sgl;
  logic [7:0] pos, next_pos;
  logic [8:0] neg, next_neg;
  logic       rise, fall, decision;
  logic [3:0] shifted;
  logic       f_sgl, f_odd, f_s1, f_s0;

  assign rise     = i_sclk & ~sclk_q;
  assign fall     = ~i_sclk & sclk_q;
  assign decision = i_comp_high & ~i_pos_below_neg;

  // next values of the conversion sequence
  always_comb begin
    next_state   = state;
    next_addr_sr = addr_sr;
    next_cnt     = cnt;
    next_trial   = trial;
    next_result  = result;
    next_dout    = dout;
    next_drive   = drive;
    next_busy    = busy;
    next_sgl     = sgl;
    next_pos     = pos;
    next_neg     = neg;
    shifted      = {addr_sr[2:0], i_serial_in};
    f_sgl        = 1'b0;
    f_odd        = 1'b0;
    f_s1         = 1'b0;
    f_s0         = 1'b0;
    if (CHANNELS == 8) begin
      {f_sgl, f_odd, f_s1, f_s0} = shifted;
    end else if (CHANNELS == 4) begin
      {f_sgl, f_odd, f_s1} = shifted[2:0];
      f_s0 = sami_pkg::SEL0_CH4;
    end else if (CHANNELS == 2) begin
      {f_sgl, f_odd} = shifted[1:0];
      f_s0 = sami_pkg::SEL0_CH2;
      f_s1 = sami_pkg::SEL1_CH2;
    end
    if (i_cs_n) begin
      next_state = sami_pkg::ST_IDLE;
      next_drive = 1'b0;
      next_busy  = 1'b0;
      next_dout  = 1'b0;
    end else begin
      case (state)
        sami_pkg::ST_IDLE: begin
          if (rise && i_serial_in) begin
            next_cnt = ADDR_N;
            if (ADDR_N == 3'h0) begin
              {next_pos, next_neg} = mux_decode(1'b0, 1'b0, 1'b0, 1'b0);
              next_sgl   = 1'b0;
              next_state = sami_pkg::ST_SETTLE;
            end else begin
              next_state = sami_pkg::ST_ADDR;
            end
          end
        end
        sami_pkg::ST_ADDR: begin
          if (rise) begin
            next_addr_sr = shifted;
            next_cnt     = cnt - sami_pkg::BIT_ONE;
            if (cnt == sami_pkg::BIT_ONE) begin
              next_sgl   = f_sgl;
              {next_pos, next_neg} = mux_decode(f_sgl, f_odd, f_s1, f_s0);
              next_state = sami_pkg::ST_SETTLE;
            end
          end
        end
        sami_pkg::ST_SETTLE: begin
          if (fall) begin
            next_busy  = 1'b1;
            next_drive = 1'b1;
            next_dout  = 1'b0;
            next_trial = sami_pkg::TRIAL_INIT;
            next_cnt   = sami_pkg::BIT_TOP;
            next_state = sami_pkg::ST_CONV;
          end
        end
        sami_pkg::ST_CONV: begin
          if (fall) begin
            next_dout           = decision;
            next_result[cnt]    = decision;
            next_trial[cnt]     = decision;       // keep the decided bit
            next_cnt            = cnt - sami_pkg::BIT_ONE;
            if (cnt == 3'h0) begin
              next_busy = 1'b0;
              next_cnt  = sami_pkg::BIT_ONE;
              if (CHANNELS == 8 && !i_shift_order_enable_n)
                next_state = sami_pkg::ST_LSB;
              else
                next_state = sami_pkg::ST_DONE;
            end else begin
              next_trial[next_cnt] = 1'b1;        // try the next bit down
            end
          end
        end
        sami_pkg::ST_LSB: begin
          if (fall) begin
            next_dout = result[cnt];
            next_cnt  = cnt + sami_pkg::BIT_ONE;
            if (cnt == sami_pkg::BIT_TOP) next_state = sami_pkg::ST_DONE;
          end
        end
        sami_pkg::ST_DONE: next_state = state;
        default: next_state = sami_pkg::ST_IDLE;
      endcase
    end
  end

  // registers of the conversion sequence
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state   <= sami_pkg::ST_IDLE;
      sclk_q  <= 1'b0;
      addr_sr <= 4'h0;
      cnt     <= 3'h0;
      trial   <= sami_pkg::ZERO8;
      result  <= sami_pkg::ZERO8;
      dout    <= 1'b0;
      drive   <= 1'b0;
      busy    <= 1'b0;
      sgl     <= 1'b0;
      pos     <= sami_pkg::ZERO8;
      neg     <= 9'h000;
    end else begin
      state   <= next_state;
      sclk_q  <= i_sclk;
      addr_sr <= next_addr_sr;
      cnt     <= next_cnt;
      trial   <= next_trial;
      result  <= next_result;
      dout    <= next_dout;
      drive   <= next_drive;
      busy    <= next_busy;
      sgl     <= next_sgl;
      pos     <= next_pos;
      neg     <= next_neg;
    end
  end

  // outputs, enables low while driving
  assign o_serial_out             = dout;
  assign o_serial_out_oe_n        = ~drive;
  assign o_conversion_active      = busy;
  assign o_conversion_active_oe_n = ~drive;
  assign o_single_ended_select    = sgl;
  assign o_pos_sel                = pos;
  assign o_neg_sel                = neg;
  assign o_ladder_code            = trial;
  assign o_result                 = result;

  // =====================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  int unsigned conv_falls;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) conv_falls <= 0;
    else if (state == sami_pkg::ST_SETTLE) conv_falls <= 0;
    else if (state == sami_pkg::ST_CONV && fall) conv_falls <= conv_falls + 1;
  end

  release_on_cs_a: assert property (i_cs_n |=>
      o_serial_out_oe_n && o_conversion_active_oe_n)
      else $error("outputs not released");
  dout_on_fall_a: assert property (!o_serial_out_oe_n
      && !$past(o_serial_out_oe_n) && $changed(o_serial_out) |-> $past(fall))
      else $error("serial output moved off a falling edge");
  eight_decisions_a: assert property (state == sami_pkg::ST_CONV
      && $past(state) == sami_pkg::ST_CONV
      |-> conv_falls < sami_pkg::CONV_BITS)
      else $error("more than eight decisions");
  settle_zero_a: assert property (state == sami_pkg::ST_SETTLE
      && fall && !i_cs_n |=> busy && drive && !dout)
      else $error("settle did not raise busy with zero");
  start_bit_a: assert property (state == sami_pkg::ST_IDLE
      && !i_cs_n && rise && !i_serial_in |=> state == sami_pkg::ST_IDLE)
      else $error("leading zero left idle");
  neg_zeros_a: assert property (state == sami_pkg::ST_CONV && fall
      && !i_cs_n && i_pos_below_neg |=> !dout)
      else $error("negative difference gave a one");
  single_com_a: assert property (CHANNELS == 8 && sgl
      |-> neg[sami_pkg::COM_BIT])
      else $error("single-ended without common return");
  pair_adjacent_a: assert property (CHANNELS > 1 && !sgl && |pos
      |-> neg[7:0] == (({pos[6:0], 1'b0} & 8'hAA)
      | ({1'b0, pos[7:1]} & 8'h55)))
      else $error("pair not adjacent");
  busy_ends_a: assert property (state == sami_pkg::ST_CONV && fall
      && cnt == 3'h0 && !i_cs_n |=> !busy)
      else $error("busy held past last bit");

  conv_done_c: cover property (state == sami_pkg::ST_CONV ##1
      state == sami_pkg::ST_DONE);
  lsb_out_c: cover property (state == sami_pkg::ST_LSB ##1
      state == sami_pkg::ST_DONE);
  abort_c: cover property (state == sami_pkg::ST_CONV ##1 i_cs_n);
endmodule : sami_core

//--- sami_host.sv
`timescale 1ns/10ps
// =====================================================
// host side: drives chip select, serial clock and data
module sami_host (
  input  wire logic i_clk,
  input  wire logic i_serial_out,
  input  wire logic i_busy,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_serial_in,
  output logic      o_se_n
);
  logic [15:0] cap;
  int          busy_cnt;
  // idle levels, clock stands low outside frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_serial_in = 1'b0;
    o_se_n = 1'b1;
  end
  // one phase of at least 1 us
  task automatic half();
    repeat (sami_pkg::MIN_PHASE_CYC) @(negedge i_clk);
  endtask : half
  // data set in low phase, output taken just before the rise
  task automatic pulse(input logic d);
    o_serial_in = d;
    half();
    cap = {cap[14:0], i_serial_out};
    if (i_busy === 1'b1) busy_cnt++;
    o_sclk = 1'b1;
    half();
    o_sclk = 1'b0;
  endtask : pulse
  // zeros, start bit, 4 address bits, then data clocks
  task automatic run(input logic [3:0] a, input int z, input int n,
                     input int se_at);
    cap = 16'h0000;
    busy_cnt = 0;
    o_cs_n = 1'b0;
    repeat (z) pulse(1'b0);
    pulse(1'b1);
    for (int i = 3; i >= 0; i--) pulse(a[i]);
    for (int r = 1; r <= n; r++) begin
      pulse(r[0]);
      if (r == se_at) o_se_n = 1'b0;
    end
  endtask : run
  // end of frame
  task automatic stop();
    o_cs_n = 1'b1;
    o_se_n = 1'b1;
    o_serial_in = 1'b0;
    @(negedge i_clk);
  endtask : stop
endmodule : sami_host

//--- sami_core_bench.sv
`timescale 1ns/10ps
// =====================================================
// bench for the serial converter core
module sami_core_bench;
  logic       clk, rst_n, cs_n, sclk, sdi, se_n, comp, below;
  logic       sdo, sdo_oe_n, busy, busy_oe_n, sgl, sdo_line;
  logic [7:0] pos, ladder, res, vin;
  logic [8:0] neg;
  int         num_errors, samples_checked;
  sami_core sami_core_i (.i_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_serial_in(sdi), .i_shift_order_enable_n(se_n),
    .i_comp_high(comp), .i_pos_below_neg(below), .o_serial_out(sdo),
    .o_serial_out_oe_n(sdo_oe_n), .o_conversion_active(busy),
    .o_conversion_active_oe_n(busy_oe_n), .o_single_ended_select(sgl),
    .o_pos_sel(pos), .o_neg_sel(neg), .o_ladder_code(ladder),
    .o_result(res));
  sami_host sami_host_i (.i_clk(clk), .i_serial_out(sdo_line), .i_busy(busy),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_serial_in(sdi), .o_se_n(se_n));
  // released data line reads high at the host
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo;
  // clock and half-LSB offset analog model
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) comp <= ({vin, 1'b1} > {ladder, 1'b0});
  // =====================================================
  // comparison and verdict
  task automatic check(input logic [15:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : check
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // =====================================================
  // every address: selects, mode, serial result, busy span
  task automatic t_mux();
    logic [2:0] b;
    for (int a = 0; a < 16; a++) begin
      vin = 8'(a * 16 + 5);
      sami_host_i.run(4'(a), 0, 9, 0);
      b = a[3] ? {a[1:0], a[2]} : {a[1:0], 1'b0};
      check(16'(sgl), 16'(a[3]), "mode");
      check(16'(pos), 16'(8'h01 << (a[3] ? b : b | a[2])), "pos");
      check(16'(neg), a[3] ? 16'h0100 : 16'(9'h001 << (b | !a[2])),
            "neg");
      check(16'(sami_host_i.cap[8:0]), 16'(vin), "serial");
      check(16'(res), 16'(vin), "result");
      check(16'(sami_host_i.busy_cnt), 16'h0008, "busy");
      sami_host_i.stop();
    end
  endtask : t_mux
  // leading zeros, then LSB-first readback
  task automatic t_lsb();
    logic [15:0] e;
    vin = 8'hB4;
    e = {8'h00, vin};
    for (int i = 1; i < 8; i++) e = {e[14:0], vin[i]};
    sami_host_i.run(4'hF, 2, 16, 8);
    check(sami_host_i.cap, e, "lsb order");
    sami_host_i.stop();
  endtask : t_lsb
  // positive below negative gives zero
  task automatic t_below();
    vin = 8'hA5;
    below = 1'b1;
    sami_host_i.run(4'h8, 0, 9, 0);
    check(sami_host_i.cap, 16'h3E00, "below serial");
    check(16'(res), 16'h0000, "below result");
    below = 1'b0;
    sami_host_i.stop();
  endtask : t_below
  // chip select rises mid-conversion, then a fresh one
  task automatic t_abort();
    vin = 8'h3C;
    sami_host_i.run(4'h3, 0, 3, 0);
    check({14'h0, sdo_oe_n, busy}, 16'h0001, "driving");
    sami_host_i.stop();
    repeat (2) @(negedge clk);
    check({13'h0, sdo_oe_n, busy_oe_n, busy}, 16'h0006, "release");
    sami_host_i.run(4'h9, 0, 9, 0);
    check(16'(sami_host_i.cap[8:0]), 16'(vin), "restart");
    sami_host_i.stop();
  endtask : t_abort
  // =====================================================
  // main sequence and watchdog
  initial begin
    rst_n = 1'b0;
    below = 1'b0;
    vin = 8'h00;
    num_errors = 0;
    samples_checked = 0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_mux();
    t_lsb();
    t_below();
    t_abort();
    give_verdict();
  end
  initial begin
    #2ms; // about three and a half times the expected run
    num_errors++;
    give_verdict();
  end
endmodule : sami_core_bench
